// File: rtl/bscan_tap.sv
`timescale 1ns/1ps
module bscan_tap
  import bscan_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire bscan_pins_s pins,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [31:0] user_code,
  input wire logic [BSR_LEN-1:0] core_val,
  input wire logic [BSR_LEN-1:0] pad_in,
  output logic [BSR_LEN-1:0] cell_drive,
  output logic host_if_off,
  output logic [RA_W-1:0] reg_addr,
  input wire logic [RD_W-1:0] reg_rdata,
  output bscan_wr_s reg_wr
);

  // ************************************
  // Pin synchronisers and edge detection
  // ************************************
  bscan_pins_s pins_s1_q;
  bscan_pins_s pins_s2_q;
  logic tck_d_q;
  logic [BSR_LEN-1:0] pad_s1_q;
  logic [BSR_LEN-1:0] pad_s2_q;

  always_ff @(posedge ref_clk) begin
    pins_s1_q <= pins;
    pins_s2_q <= pins_s1_q;
    pad_s1_q <= pad_in;
    pad_s2_q <= pad_s1_q;
    // Follows the pin through reset so an idle-high clock gives no false edge
    tck_d_q <= pins_s2_q.tck;
  end

  // Without edges only cell_drive (following core_val) and the end of the reg_wr valid pulse move below
  wire tck_rise = pins_s2_q.tck & ~tck_d_q;
  wire tck_fall = ~pins_s2_q.tck & tck_d_q;
  wire tms_smp = pins_s2_q.tms;
  wire tdi_smp = pins_s2_q.tdi;

  // ************************************
  // Controller
  // ************************************
  function automatic bscan_state_e tap_next(input bscan_state_e s,
                                            input logic m);
    unique case (s)
      TLR: tap_next = m ? TLR : RTI;
      RTI: tap_next = m ? SEL_DR : RTI;
      SEL_DR: tap_next = m ? SEL_IR : CAP_DR;
      CAP_DR: tap_next = m ? EX1_DR : SH_DR;
      SH_DR: tap_next = m ? EX1_DR : SH_DR;
      EX1_DR: tap_next = m ? UPD_DR : PA_DR;
      PA_DR: tap_next = m ? EX2_DR : PA_DR;
      EX2_DR: tap_next = m ? UPD_DR : SH_DR;
      UPD_DR: tap_next = m ? SEL_DR : RTI;
      SEL_IR: tap_next = m ? TLR : CAP_IR;
      CAP_IR: tap_next = m ? EX1_IR : SH_IR;
      SH_IR: tap_next = m ? EX1_IR : SH_IR;
      EX1_IR: tap_next = m ? UPD_IR : PA_IR;
      PA_IR: tap_next = m ? EX2_IR : PA_IR;
      EX2_IR: tap_next = m ? UPD_IR : SH_IR;
      UPD_IR: tap_next = m ? SEL_DR : RTI;
    endcase
  endfunction

  bscan_state_e state_q;
  bscan_state_e state_d;

  assign state_d = tck_rise ? tap_next(state_q, tms_smp) : state_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= TLR;
    end else begin
      state_q <= state_d;
    end
  end

  // ************************************
  // Instruction register
  // ************************************
  logic [IR_W-1:0] ir_sh_q;
  logic [IR_W-1:0] ir_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ir_sh_q <= IR_CAPT_VAL;
      ir_q <= IR_IDCODE;
    end else if (tck_rise) begin
      if (state_q == CAP_IR) begin
        ir_sh_q <= IR_CAPT_VAL;
      end else if (state_q == SH_IR) begin
        ir_sh_q <= {tdi_smp, ir_sh_q[IR_W-1:1]};
      end
      if (state_d == TLR) begin
        ir_q <= IR_IDCODE;
      end else if (state_q == UPD_IR) begin
        ir_q <= ir_sh_q;
      end
    end
  end

  // ************************************
  // Instruction decode
  // ************************************
  function automatic logic [IR_W-1:0] ir_norm(input logic [IR_W-1:0] c);
    unique case (c)
      IR_SAMPLE, IR_IDCODE, IR_USER, IR_CLAMP, IR_HIGHZ,
      IR_EXTEST, IR_IFONOFF, IR_REGRD, IR_REGWR: ir_norm = c;
      default: ir_norm = IR_BYPASS;
    endcase
  endfunction

  function automatic logic [5:0] dr_len(input logic [IR_W-1:0] c);
    unique case (c)
      IR_SAMPLE, IR_EXTEST: dr_len = LEN_BSR;
      IR_IDCODE, IR_USER: dr_len = LEN_ID;
      IR_IFONOFF: dr_len = LEN_IF;
      IR_REGRD, IR_REGWR: dr_len = LEN_REG;
      default: dr_len = LEN_BYP;
    endcase
  endfunction

  wire [IR_W-1:0] ins = ir_norm(ir_q);
  wire bsr_sel = (ins == IR_SAMPLE) | (ins == IR_EXTEST);
  wire drive_upd = (ins == IR_EXTEST) | (ins == IR_CLAMP);
  wire highz = ins == IR_HIGHZ;
  wire [5:0] len = dr_len(ins);

  // ************************************
  // Boundary cells
  // ************************************
  logic [BSR_LEN-1:0] bsr_upd_q;
  logic [BSR_LEN-1:0] bsr_cap;
  logic [BSR_LEN-1:0] drive_d;

  // Cell 22 is the clock output pad, cell 0 the signal output pad
  for (genvar i = 0; i < BSR_LEN; i++) begin : g_cell
    localparam bit IS_CTRL = CTRL_MASK[i];
    localparam bit IS_OUT = OUT_MASK[i];
    localparam bit IS_IN4 = IN4_MASK[i];
    // BC_1 cells capture the core value; BC_8 and BC_4 capture the pad
    assign bsr_cap[i] = (IS_CTRL | IS_OUT) ? core_val[i] : pad_s2_q[i];
    if (IS_IN4) begin : g_in4
      assign drive_d[i] = core_val[i];
    end else if (IS_CTRL) begin : g_ctl
      assign drive_d[i] = highz ? 1'b0 :
                          (drive_upd ? bsr_upd_q[i] : core_val[i]);
    end else begin : g_dat
      assign drive_d[i] = drive_upd ? bsr_upd_q[i] : core_val[i];
    end
  end

  // ************************************
  // Data register
  // ************************************
  logic [DR_W-1:0] dr_q;
  logic if_off_q;
  logic [RA_W-1:0] addr_q;
  logic [DR_W-1:0] dr_cap;
  logic [DR_W-1:0] dr_shift;

  wire [DR_W-1:0] id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  wire [DR_W-1:0] top_bit = 32'h1 << (len - 6'h01);

  always_comb begin
    unique case (ins)
      IR_SAMPLE, IR_EXTEST: dr_cap = {8'h00, bsr_cap};
      IR_IDCODE: dr_cap = id_word;
      IR_USER: dr_cap = user_code;
      IR_IFONOFF: dr_cap = {31'h0, if_off_q};
      IR_REGRD: dr_cap = {17'h0, reg_rdata, addr_q};
      default: dr_cap = 32'h0;
    endcase
  end

  // Serial path: input enters at bit len-1, bit 0 faces the output
  assign dr_shift = ({1'b0, dr_q[DR_W-1:1]} & ~top_bit) |
                    (tdi_smp ? top_bit : 32'h0);

  wire upd_dr = tck_rise & (state_q == UPD_DR);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dr_q <= 32'h0;
    end else if (tck_rise) begin
      if (state_q == CAP_DR) begin
        dr_q <= dr_cap;
      end else if (state_q == SH_DR) begin
        dr_q <= dr_shift;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bsr_upd_q <= BSR_RST;
      if_off_q <= 1'b0;
      addr_q <= ADDR_RST;
    end else if (upd_dr) begin
      if (bsr_sel) begin
        bsr_upd_q <= dr_q[BSR_LEN-1:0];
      end
      if (ins == IR_IFONOFF) begin
        if_off_q <= dr_q[0];
      end
      if ((ins == IR_REGRD) && if_off_q) begin
        addr_q <= dr_q[RA_W-1:0];
      end
    end
  end

  // ************************************
  // Register write strobe
  // ************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_wr <= '0;
    end else begin
      reg_wr.valid <= upd_dr & (ins == IR_REGWR) & if_off_q;
      if (upd_dr & (ins == IR_REGWR)) begin
        reg_wr.addr <= dr_q[RA_W-1:0];
        reg_wr.data <= dr_q[RA_W+RD_W-1:RA_W];
      end
    end
  end

  // ************************************
  // Test data output
  // ************************************
  wire shifting = (state_q == SH_DR) | (state_q == SH_IR);
  wire out_bit = (state_q == SH_IR) ? ir_sh_q[0] : dr_q[0];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo <= shifting ? out_bit : 1'b0;
      tdo_oe <= shifting;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cell_drive <= BSR_RST;
    end else begin
      cell_drive <= drive_d;
    end
  end

  assign host_if_off = if_off_q;
  assign reg_addr = addr_q;

endmodule

// File: shared/bscan_pkg.sv
// Contract
// - Clock and mode select shared by chain; data passes serially input to output.
// - Controller samples mode select on rising test clock; next state from both.
// - Mode select high for five clocks reaches Test-Logic-Reset from anywhere.
// - Entering Test-Logic-Reset loads the identification instruction.
// - Stopped test clock leaves state and all scan registers unchanged.
// - Data input sampled on rising edge into the chain state and instruction pick.
// - Data output updates on falling edge from the accessed chain.
// - Data output is not driven outside shift states.
// - Bypass passes data through one bit without disturbing the device.
// - Shifted data register length depends on the active instruction.
// - Boundary cells 23 to 0; data cell under control; 22 clock out, 0 signal out.
// - Bidir pins BC_8, serial-bus pin BC_4, every output enable a BC_1 cell.
// - Identification: 4-bit version, 16-bit part, 11-bit maker, lsb one.
// - User code shifts four nonvolatile bytes: 3-byte product id, one version.
// - Interface on/off at Update-DR; one disables host ports, enables scan access.
// - Read access: capture current address, shift new address, update makes it current.
// - Codes 0,1,2,3,4,5,7,8,9,10 with listed register lengths.
package bscan_pkg;
  localparam int IR_W = 4;
  localparam int DR_W = 32;
  localparam int BSR_LEN = 24;
  localparam int RA_W = 7;
  localparam int RD_W = 8;
  localparam logic [5:0] LEN_BYP = 6'h01;
  localparam logic [5:0] LEN_BSR = 6'h18;
  localparam logic [5:0] LEN_ID = 6'h20;
  localparam logic [5:0] LEN_IF = 6'h01;
  localparam logic [5:0] LEN_REG = 6'h0f;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'h0;
  localparam logic [IR_W-1:0] IR_SAMPLE = 4'h1;
  localparam logic [IR_W-1:0] IR_IDCODE = 4'h2;
  localparam logic [IR_W-1:0] IR_USER = 4'h3;
  localparam logic [IR_W-1:0] IR_CLAMP = 4'h4;
  localparam logic [IR_W-1:0] IR_HIGHZ = 4'h5;
  localparam logic [IR_W-1:0] IR_EXTEST = 4'h7;
  localparam logic [IR_W-1:0] IR_IFONOFF = 4'h8;
  localparam logic [IR_W-1:0] IR_REGRD = 4'h9;
  localparam logic [IR_W-1:0] IR_REGWR = 4'ha;
  localparam logic [IR_W-1:0] IR_CAPT_VAL = 4'h1;
  // Identification fields, values arbitrary
  localparam logic [3:0] ID_VERSION = 4'h5;
  localparam logic [15:0] ID_PART = 16'h1234;
  localparam logic [10:0] ID_MAKER = 11'h155;
  // Cell kinds: BC_1 control, BC_1 output, BC_4 input, rest BC_8
  localparam logic [BSR_LEN-1:0] CTRL_MASK = 24'haaaa2a;
  localparam logic [BSR_LEN-1:0] OUT_MASK = 24'h000080;
  localparam logic [BSR_LEN-1:0] IN4_MASK = 24'h000040;
  localparam int CELL_CLOCK_OUTPUT_PIN = 22;
  localparam int CELL_CONTACTLESS_SIGNAL_OUT_PIN = 0;
  localparam logic [BSR_LEN-1:0] BSR_RST = 24'h000000;
  localparam logic [RA_W-1:0] ADDR_RST = 7'h00;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } bscan_state_e;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bscan_pins_s;

  typedef struct packed {
    logic valid;
    logic [RA_W-1:0] addr;
    logic [RD_W-1:0] data;
  } bscan_wr_s;
endpackage

// File: dv/bscan_tap_assertions.sv
`timescale 1ns/1ps
module bscan_tap_assertions
  import bscan_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire bscan_pins_s pins,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic host_if_off,
  input wire logic [RA_W-1:0] reg_addr,
  input wire bscan_wr_s reg_wr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ***
  // Port checks
  // ***
  chk_reset_quiet: assert property (
    $fell(rst) |-> !tdo_oe && !host_if_off && !reg_wr.valid) else $error("busy after reset");
  chk_idle_low: assert property (!tdo_oe |-> !tdo) else $error("tdo set while idle");
  chk_oe_on_fall: assert property (
    $changed(tdo_oe) |-> !pins.tck) else $error("enable moved with tck high");
  chk_tdo_on_fall: assert property (
    $changed(tdo) |-> !pins.tck) else $error("tdo moved with tck high");
  chk_stopped_hold: assert property ($stable(pins.tck)[*8] |->
    $stable(tdo) && $stable(tdo_oe) && $stable(host_if_off) && $stable(reg_addr))
    else $error("state moved with tck stopped");
  chk_wr_pulse: assert property (
    reg_wr.valid |=> !reg_wr.valid) else $error("write pulse too long");
  chk_wr_gated: assert property (
    reg_wr.valid |-> host_if_off) else $error("write with ports on");
  chk_addr_gated: assert property (
    $changed(reg_addr) |-> host_if_off) else $error("address moved with ports on");
endmodule
bind bscan_tap bscan_tap_assertions u_chk (.ref_clk(ref_clk), .rst(rst), .pins(pins),
  .tdo(tdo), .tdo_oe(tdo_oe), .host_if_off(host_if_off), .reg_addr(reg_addr),
  .reg_wr(reg_wr));

// File: dv/bscan_tester.sv
`timescale 1ns/1ps
module bscan_tester
  import bscan_pkg::*;
(
  output bscan_pins_s pins,
  input wire logic tdo
);
  // Pulled-up lines idle high, tck stands still between frames
  initial pins = 3'b111;
  // ***
  // Tester cycles
  // ***
  task automatic cyc(input logic ms, input logic di, output logic o);
    pins.tck <= 1'b0;
    pins.tms <= ms;
    pins.tdi <= di;
    #24;
    pins.tck <= 1'b1;
    #24;
    o = tdo;
  endtask
  task automatic to_idle(input int ones);
    logic o;
    repeat (ones) cyc(1'b1, 1'b1, o);
    cyc(1'b0, 1'b1, o);
  endtask
  // From idle through capture, shift and update back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
    dout = '0;
    cyc(1'b1, 1'b1, o);
    if (ir)
      cyc(1'b1, 1'b1, o);
    cyc(1'b0, 1'b1, o);
    cyc(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i], o);
      dout[i] = o;
    end
    cyc(1'b1, 1'b1, o);
    cyc(1'b0, 1'b1, o);
  endtask
endmodule

// File: dv/tb_bscan_tap.sv
`timescale 1ns/1ps
module tb_bscan_tap
  import bscan_pkg::*;
;
  localparam logic [31:0] UCODE = 32'hc0ffee21;
  localparam logic [31:0] IDC = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  localparam logic [BSR_LEN-1:0] CORE = 24'h5a3c96;
  localparam logic [BSR_LEN-1:0] PADS = 24'h93c5a6;
  localparam logic [BSR_LEN-1:0] KEEP = CTRL_MASK | OUT_MASK;
  localparam logic [RD_W-1:0] RDATA = 8'h6d;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  bscan_pins_s pins;
  logic tdo, tdo_oe, host_if_off;
  logic [BSR_LEN-1:0] cell_drive;
  logic [RA_W-1:0] reg_addr;
  bscan_wr_s reg_wr, wr_last;
  logic [31:0] d;
  int n_fail = 0, tests_run = 0, wr_cnt = 0, cyc_n = 0;
  always #2.5 ref_clk = ~ref_clk;
  bscan_tap dut (.ref_clk(ref_clk), .rst(rst), .pins(pins), .tdo(tdo), .tdo_oe(tdo_oe),
    .user_code(UCODE), .core_val(CORE), .pad_in(PADS), .cell_drive(cell_drive),
    .host_if_off(host_if_off), .reg_addr(reg_addr), .reg_rdata(RDATA), .reg_wr(reg_wr));
  bscan_tester tst (.pins(pins), .tdo(tdo));
  always @(posedge ref_clk) begin
    if (reg_wr.valid === 1'b1) begin
      wr_cnt++;
      wr_last <= reg_wr;
    end
    cyc_n++;
    if (cyc_n == 30000) begin
      n_fail++;
      wrap_up();
    end
  end
  // ***
  // Checks and scenarios
  // ***
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic t_idcode();
    tst.scan(1'b0, 32, '0, d);
    chk(d, IDC);
    chk(tdo_oe, 1'b0);
    $display("idcode test done");
  endtask
  task automatic t_user();
    tst.scan(1'b1, 4, IR_USER, d);
    chk(d[3:0], IR_CAPT_VAL);
    tst.scan(1'b0, 32, '0, d);
    chk(d, UCODE);
    tst.to_idle(5);
    tst.scan(1'b0, 32, '0, d);
    chk(d, IDC);
    $display("user code test done");
  endtask
  task automatic t_bypass();
    logic [3:0] codes [5] = '{IR_BYPASS, IR_CLAMP, IR_HIGHZ, 4'h6, 4'hf};
    foreach (codes[k]) begin
      tst.scan(1'b1, 4, codes[k], d);
      tst.scan(1'b0, 8, 8'hb5, d);
      chk(d[7:0], 8'h6a);
      if (codes[k] == IR_HIGHZ)
        chk(cell_drive & CTRL_MASK, 24'h000000);
    end
    $display("bypass test done");
  endtask
  task automatic t_bsr();
    tst.scan(1'b1, 4, IR_SAMPLE, d);
    tst.scan(1'b0, 24, 24'h0f0f0f, d);
    chk(d[23:0], (CORE & KEEP) | (PADS & ~KEEP));
    tst.scan(1'b1, 4, IR_EXTEST, d);
    tst.scan(1'b0, 24, 24'h0f0f0f, d);
    chk(cell_drive, 24'h0f0f0f);
    $display("boundary test done");
  endtask
  task automatic t_regs();
    int n;
    n = wr_cnt;
    tst.scan(1'b1, 4, IR_REGWR, d);
    tst.scan(1'b0, 15, {8'hc3, 7'h15}, d);
    chk(wr_cnt, n);
    tst.scan(1'b1, 4, IR_IFONOFF, d);
    tst.scan(1'b0, 1, 32'h1, d);
    chk(host_if_off, 1'b1);
    tst.scan(1'b1, 4, IR_REGWR, d);
    tst.scan(1'b0, 15, {8'hc3, 7'h15}, d);
    chk(wr_cnt, n + 1);
    chk({wr_last.data, wr_last.addr}, {8'hc3, 7'h15});
    tst.scan(1'b1, 4, IR_REGRD, d);
    tst.scan(1'b0, 15, 7'h2a, d);
    chk(reg_addr, 7'h2a);
    tst.scan(1'b0, 15, 7'h2a, d);
    chk(d[14:0], {RDATA, 7'h2a});
    $display("register access test done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    tst.to_idle(0);
    t_idcode();
    repeat (200) @(posedge ref_clk);
    t_user();
    t_bypass();
    t_bsr();
    t_regs();
    wrap_up();
  end
endmodule
